// ==== inc/dsm_defs.svh ====
// Timing counts and display codes for the dual-slope meter sequencer
// Assumes a 50 MHz clock; counts are in clock periods
`ifndef DSM_DEFS_SVH
`define DSM_DEFS_SVH
`define DSM_REF_PERIOD      17'd18000
`define DSM_POS_OVR_END     17'd20000
`define DSM_POS_ZERO        17'd39999
`define DSM_NEG_ZERO        17'd40000
`define DSM_NEG_OVR         17'd60000
`define DSM_COUNT_MAX       17'd79999
`define DSM_MUX_ZERO_LEN    12'd256
`define DSM_OC_LEN          12'd256
`define DSM_PD_LEN          12'd256
`define DSM_INIT_LEN        12'd256
`define DSM_RU_LEN          13'd4096
`define DSM_RR_MAX          13'd8191
`endif

// ==== inc/dsm_pkg.sv ====
// Types for the dual-slope meter sequencer
// Assumes dsm_defs.svh carries the numeric constants
package dsm_pkg;
  typedef enum logic [2:0]
  {
    PH_OFFSET = 3'b000,
    PH_POLDET = 3'b001,
    PH_INIT   = 3'b010,
    PH_RAMPX  = 3'b011,
    PH_RAMPR  = 3'b100
  } phase_type;

  typedef struct packed
  {
    logic        sign_minus;
    logic        overrange;
    logic [16:0] magnitude;
  } reading_type;

  typedef struct packed
  {
    logic offset_corr;
    logic pol_det;
    logic ramp_unknown;
    logic ramp_ref;
    logic mux_enable;
    logic [1:0] channel;
  } front_type;
endpackage

// ==== rtl/dual_slope_meter_sequencer.sv ====
// Dual-slope converter sequencer: panel-meter timing and count decode,
// plus a five-phase autozeroed binary conversion with channel select.
// Assumes comparator input is already synchronous to clock_i.
`include "dsm_defs.svh"
`timescale 1ns/1ps
`default_nettype none

// How it works
// - From release of the meter reset the integrate output stays high for exactly 18000 clocks.
// - After that period the reference is applied and counting goes on, holding at 79999 until the next reset.
// - On the trip the count is copied to the output latch once; later transfers are ignored until the next reset.
// - A trip within 2000 counts after the period gives plus overrange with digits blanked.
// - A trip at 20000 reads +19999, falling by one per count to +0000 at 39999.
// - A trip at 40000 reads -0000, rising by one per count, and 60000 gives minus overrange.
// - Reset and transfer act only on clock edges so latched readings never change mid-cycle.
// - In the acquisition sequence the shared zeroing phase lasts 256 clocks.
// - The amplifier is zeroed at power-up and after each conversion with the mux off, mux on otherwise.
// - A 2-bit up counter picks one of four channels and advances once per conversion.
// - The binary counter counts clocks only during the reference ramp.
// - The binary count is latched when the comparator output goes low.
// - Each binary conversion walks offset, polarity, init, ramp unknown, ramp reference in order.
// - The unknown ramp lasts exactly 4096 clocks and the reference ramp is counted for the result.
module dual_slope_meter_sequencer
(
  input  wire logic                 clock_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 meter_reset_n_i,
  input  wire logic                 transfer_n_i,
  input  wire logic                 comp_i,
  output logic                      integrate_o,
  output logic                      reading_valid_o,
  output dsm_pkg::reading_type      reading_o,
  output dsm_pkg::front_type        front_o,
  output logic                      bin_sign_o,
  output logic [12:0]               bin_result_o,
  output logic                      bin_valid_o
);
  import dsm_pkg::*;

  function automatic reading_type decode_count(input logic [16:0] cnt);
    reading_type r;
    r = '0;
    if (cnt < `DSM_POS_OVR_END)
    begin
      r.overrange = 1'b1;
    end
    else if (cnt <= `DSM_POS_ZERO)
    begin
      r.magnitude = 17'(`DSM_POS_ZERO - cnt);
    end
    else if (cnt < `DSM_NEG_OVR)
    begin
      r.sign_minus = 1'b1;
      r.magnitude  = 17'(cnt - `DSM_NEG_ZERO);
    end
    else
    begin
      r.sign_minus = 1'b1;
      r.overrange  = 1'b1;
    end
    return r;
  endfunction

  // Final clock of a timed phase
  function automatic logic last_tick(input logic [12:0] t, input logic [12:0] len);
    return t == len - 13'd1;
  endfunction

  // Switch controls for the analog front end
  function automatic front_type front_for(input phase_type ph, input logic [1:0] ch);
    front_type f;
    f              = '0;
    f.offset_corr  = (ph == PH_OFFSET) || (ph == PH_INIT);
    f.pol_det      = (ph == PH_POLDET);
    f.ramp_unknown = (ph == PH_RAMPX);
    f.ramp_ref     = (ph == PH_RAMPR);
    f.mux_enable   = (ph != PH_OFFSET);
    f.channel      = ch;
    return f;
  endfunction

  // Panel-meter section
  logic        rst_seen_q;
  logic        rst_seen_d;
  logic        running_q;
  logic        running_d;
  logic [16:0] count_q;
  logic [16:0] count_d;
  logic        integ_q;
  logic        integ_d;
  logic        xfer_done_q;
  logic        xfer_done_d;
  reading_type reading_q;
  reading_type reading_d;
  logic        rvalid_q;
  logic        rvalid_d;

  wire         reset_rise = rst_seen_q && meter_reset_n_i;
  wire         end_ref    = running_q && (count_q == `DSM_REF_PERIOD - 17'd1);
  wire         in_ref     = running_q && !integ_q;
  wire         do_xfer    = in_ref && !xfer_done_q && !transfer_n_i;

  always_comb
  begin
    rst_seen_d  = !meter_reset_n_i;
    running_d   = running_q;
    count_d     = count_q;
    integ_d     = integ_q;
    xfer_done_d = xfer_done_q;
    reading_d   = reading_q;
    rvalid_d    = rvalid_q;
    if (!meter_reset_n_i)
    begin
      running_d   = 1'b0;
      count_d     = '0;
      integ_d     = 1'b0;
    end
    else if (reset_rise)
    begin
      running_d   = 1'b1;
      count_d     = '0;
      integ_d     = 1'b1;
      xfer_done_d = 1'b0;
    end
    else if (running_q)
    begin
      count_d = (count_q == `DSM_COUNT_MAX) ? count_q : count_q + 17'd1;
      if (end_ref)
      begin
        integ_d = 1'b0;
      end
      if (do_xfer)
      begin
        reading_d   = decode_count(count_q);
        rvalid_d    = 1'b1;
        xfer_done_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_seen_q  <= 1'b0;
      running_q   <= 1'b0;
      count_q     <= '0;
      integ_q     <= 1'b0;
      xfer_done_q <= 1'b0;
      reading_q   <= '0;
      rvalid_q    <= 1'b0;
    end
    else
    begin
      rst_seen_q  <= rst_seen_d;
      running_q   <= running_d;
      count_q     <= count_d;
      integ_q     <= integ_d;
      xfer_done_q <= xfer_done_d;
      reading_q   <= reading_d;
      rvalid_q    <= rvalid_d;
    end
  end

  // Binary converter section
  phase_type   phase_q;
  phase_type   phase_d;
  logic [12:0] tmr_q;
  logic [12:0] tmr_d;
  logic [12:0] ref_cnt_q;
  logic [12:0] ref_cnt_d;
  logic        sign_q;
  logic        sign_d;
  logic [1:0]  chan_q;
  logic [1:0]  chan_d;
  logic [12:0] bres_q;
  logic [12:0] bres_d;
  logic        bsign_q;
  logic        bsign_d;
  logic        bvalid_q;
  logic        bvalid_d;
  logic        comp_prev_q;
  front_type   front_q;
  front_type   front_d;

  // Comparator edge seen only during the reference ramp
  wire comp_fall = (phase_q == PH_RAMPR) && comp_prev_q && !comp_i;
  wire tmr_last  = last_tick(tmr_q, 13'(`DSM_MUX_ZERO_LEN));
  wire pd_last   = last_tick(tmr_q, 13'(`DSM_PD_LEN));
  wire init_last = last_tick(tmr_q, 13'(`DSM_INIT_LEN));
  wire ru_last   = last_tick(tmr_q, `DSM_RU_LEN);

  // Switch controls from flops so the analog switches see no decode glitches
  assign front_d = front_for(phase_d, chan_d);

  always_comb
  begin
    phase_d   = phase_q;
    tmr_d     = tmr_q + 13'd1;
    ref_cnt_d = ref_cnt_q;
    sign_d    = sign_q;
    chan_d    = chan_q;
    bres_d    = bres_q;
    bsign_d   = bsign_q;
    bvalid_d  = 1'b0;
    case (phase_q)
      PH_OFFSET:
      begin
        if (tmr_last)
        begin
          phase_d = PH_POLDET;
          tmr_d   = '0;
        end
      end
      PH_POLDET:
      begin
        if (pd_last)
        begin
          sign_d  = !comp_i;                   // High comparator means positive input
          phase_d = PH_INIT;
          tmr_d   = '0;
        end
      end
      PH_INIT:
      begin
        if (init_last)
        begin
          phase_d = PH_RAMPX;
          tmr_d   = '0;
        end
      end
      PH_RAMPX:
      begin
        if (ru_last)
        begin
          phase_d   = PH_RAMPR;
          tmr_d     = '0;
          ref_cnt_d = '0;
        end
      end
      PH_RAMPR:
      begin
        tmr_d = '0;
        if (ref_cnt_q != `DSM_RR_MAX)
        begin
          ref_cnt_d = ref_cnt_q + 13'd1;
        end
        if (comp_fall || ref_cnt_q == `DSM_RR_MAX)
        begin
          bres_d   = ref_cnt_q;
          bsign_d  = sign_q;
          bvalid_d = 1'b1;
          chan_d   = chan_q + 2'd1;
          phase_d  = PH_OFFSET;
        end
      end
      default:
      begin
        phase_d = PH_OFFSET;
        tmr_d   = '0;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      phase_q     <= PH_OFFSET;
      tmr_q       <= '0;
      ref_cnt_q   <= '0;
      sign_q      <= 1'b0;
      chan_q      <= 2'b00;
      bres_q      <= '0;
      bsign_q     <= 1'b0;
      bvalid_q    <= 1'b0;
      comp_prev_q <= 1'b0;
      front_q     <= '{offset_corr: 1'b1, pol_det: 1'b0, ramp_unknown: 1'b0,
                       ramp_ref: 1'b0, mux_enable: 1'b0, channel: 2'b00};
    end
    else
    begin
      phase_q     <= phase_d;
      tmr_q       <= tmr_d;
      ref_cnt_q   <= ref_cnt_d;
      sign_q      <= sign_d;
      chan_q      <= chan_d;
      bres_q      <= bres_d;
      bsign_q     <= bsign_d;
      bvalid_q    <= bvalid_d;
      comp_prev_q <= comp_i;
      front_q     <= front_d;
    end
  end

  assign integrate_o          = integ_q;
  assign reading_valid_o      = rvalid_q;
  assign reading_o            = reading_q;
  assign front_o              = front_q;
  assign bin_sign_o           = bsign_q;
  assign bin_result_o         = bres_q;
  assign bin_valid_o          = bvalid_q;
endmodule
`default_nettype wire

// ==== verif/dsm_check_assertions.sv ====
// Port checker for the meter sequencer
// Assumes single clock, async active-low reset
`timescale 1ns/1ps
`default_nettype none
module dsm_check
(
  input wire logic               clock_i,
  input wire logic               rst_n_i,
  input wire logic               integrate_o,
  input wire dsm_pkg::reading_type reading_o,
  input wire dsm_pkg::front_type front_o,
  input wire logic               bin_valid_o
);
  import dsm_pkg::*;
  logic [14:0] i_q;
  logic [12:0] u_q;
  logic [8:0]  o_q;
  logic        v_q;
  logic        pd_seen_q;
  always_ff @(posedge clock_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      pd_seen_q <= 1'b0;
      i_q <= 15'h0000;
      u_q <= 13'h0000;
      o_q <= 9'h000;
      v_q <= 1'b0;
    end
    else
    begin
      i_q <= integrate_o ? i_q + 15'h0001 : 15'h0000;
      u_q <= front_o.ramp_unknown ? u_q + 13'h0001 : 13'h0000;
      o_q <= front_o.offset_corr ? o_q + 9'h001 : 9'h000;
      v_q <= v_q | bin_valid_o;
      // Polarity phase seen in this conversion, cleared by the reference ramp
      pd_seen_q <= front_o.pol_det ? 1'b1 : front_o.ramp_ref ? 1'b0 : pd_seen_q;
    end
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);
  AST_INT_LEN: assert property ($fell(integrate_o) |-> i_q == 15'h4650)
    else $error("integrate width wrong");
  AST_RU_LEN: assert property ($fell(front_o.ramp_unknown) |-> u_q == 13'h1000)
    else $error("unknown ramp length wrong");
  AST_OC_LEN: assert property ($fell(front_o.offset_corr) && v_q |-> o_q == 9'h100)
    else $error("zeroing length wrong");
  AST_MUX: assert property (front_o.mux_enable == !(front_o.offset_corr && !pd_seen_q))
    else $error("mux enable wrong");
  AST_PD_NEXT: assert property ($fell(front_o.offset_corr) |-> (pd_seen_q ? front_o.ramp_unknown : front_o.pol_det))
    else $error("polarity phase missing");
  AST_OC_QUIET: assert property (front_o.offset_corr |=> !bin_valid_o && $stable(front_o.channel))
    else $error("result taken during zeroing");
  AST_INIT: assert property ($fell(front_o.pol_det) |-> !front_o.ramp_unknown [*8])
    else $error("init phase skipped");
  AST_RR_NEXT: assert property ($fell(front_o.ramp_unknown) |-> front_o.ramp_ref)
    else $error("reference ramp missing");
  AST_CHAN: assert property (bin_valid_o |-> front_o.channel == $past(front_o.channel) + 2'h1)
    else $error("channel not advanced");
  AST_DONE: assert property (bin_valid_o |-> $past(front_o.ramp_ref) && front_o.offset_corr ##1 !bin_valid_o)
    else $error("result latch timing wrong");
  AST_HOLD: assert property (!$stable(reading_o) |-> $past(integrate_o) == 1'b0)
    else $error("reading changed while integrating");
  cover property (bin_valid_o);
  cover property ($fell(integrate_o));
  cover property (!$stable(reading_o) && reading_o.sign_minus);
endmodule
bind dual_slope_meter_sequencer dsm_check dsm_check_inst
(
  .clock_i    (clock_i),
  .rst_n_i    (rst_n_i),
  .integrate_o(integrate_o),
  .reading_o  (reading_o),
  .front_o    (front_o),
  .bin_valid_o(bin_valid_o)
);
`default_nettype wire

// ==== verif/dsm_front_model.sv ====
// Analog front end: comparator and transfer pulse
// Assumes bench sets polarity, ramp and transfer count
`timescale 1ns/1ps
`default_nettype none
module dsm_front_model
(
  input  wire logic               clock_i,
  input  wire logic               rst_n_i,
  input  wire dsm_pkg::front_type front_i,
  input  wire logic               integrate_i,
  input  wire logic               pos_i,
  input  wire logic [12:0]        rr_i,
  input  wire logic [16:0]        xfer_at_i,
  output logic                    comp_o,
  output logic                    transfer_n_o
);
  import dsm_pkg::*;
  logic [12:0] r_q;
  logic [16:0] k_q;
  always_ff @(posedge clock_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      r_q <= 13'h0000;
      k_q <= 17'h0_0000;
      comp_o <= 1'b0;
      transfer_n_o <= 1'b1;
    end
    else
    begin
      r_q <= front_i.ramp_ref ? r_q + 13'h0001 : 13'h0000;
      // Chatter while zeroing
      if (front_i.offset_corr)
        comp_o <= !comp_o;
      else if (front_i.ramp_ref)
        comp_o <= r_q < rr_i;
      else
        comp_o <= pos_i;
      k_q <= integrate_i ? 17'h0_0000 : k_q + 17'h0_0001;
      // Low from total count xfer_at on
      transfer_n_o <= integrate_i || (k_q + 17'h0_4651 < xfer_at_i);
    end
endmodule
`default_nettype wire

// ==== verif/dual_slope_meter_sequencer_test.sv ====
// Testbench for the meter sequencer
// Assumes 50 MHz clock and the front end model
`timescale 1ns/1ps
`default_nettype none
module dual_slope_meter_sequencer_test;
  import dsm_pkg::*;
  logic clock_i, rst_n_i, meter_reset_n, transfer_n, comp, integrate, reading_valid;
  logic bin_sign, bin_valid, pos;
  logic [12:0] bin_result;
  logic [12:0] rr;
  logic [16:0] xfer_at;
  reading_type reading;
  front_type   front;
  int          err_count;
  int          n_tests;
  dual_slope_meter_sequencer dual_slope_meter_sequencer_inst
  (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .meter_reset_n_i(meter_reset_n),
    .transfer_n_i(transfer_n), .comp_i(comp), .integrate_o(integrate),
    .reading_valid_o(reading_valid), .reading_o(reading), .front_o(front),
    .bin_sign_o(bin_sign), .bin_result_o(bin_result), .bin_valid_o(bin_valid)
  );
  dsm_front_model dsm_front_model_inst
  (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .front_i(front), .integrate_i(integrate),
    .pos_i(pos), .rr_i(rr), .xfer_at_i(xfer_at), .comp_o(comp), .transfer_n_o(transfer_n)
  );
  initial
  begin
    clock_i = 1'b0;
    forever #10 clock_i = !clock_i;
  end
  task automatic stop_test();
    $display("mismatches %0d of %0d checks", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [19:0] got, input logic [19:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bounded wait, sampled at the falling edge
  task automatic waitc(input int sel, input int lim);
    int i;
    for (i = 0; i < lim; i++)
    begin
      @(negedge clock_i);
      if (sel == 0 ? bin_valid === 1'b1 : sel == 1 ? front.offset_corr === 1'b1 :
          sel == 2 ? transfer_n === 1'b0 : integrate === 1'b1)
        break;
    end
    if (i == lim)
    begin
      err_count++;
      stop_test();
    end
  endtask
  task automatic meter_run(input logic [16:0] c, input logic [19:0] exp, input logic [19:0] msk);
    @(posedge clock_i);
    xfer_at <= c;
    meter_reset_n <= 1'b0;
    @(posedge clock_i);
    meter_reset_n <= 1'b1;
    waitc(3, 10);
    waitc(2, 70000);
    repeat (2) @(negedge clock_i);
    check({reading_valid, reading} & msk, exp);
    repeat (100) @(negedge clock_i);
    check({reading_valid, reading} & msk, exp);
  endtask
  task automatic bin_run(input logic p, input logic [12:0] r, output logic [12:0] res);
    @(posedge clock_i);
    pos <= p;
    rr <= r;
    waitc(1, 6000);
    waitc(0, 20000);
    check(20'(bin_sign), 20'(!p));
    res = bin_result;
  endtask
  task automatic meter_seq();
    meter_run(17'h0_4e1f, 20'hA_0000, 20'hE_0000);
    meter_run(17'h0_4e20, 20'h8_4E1F, 20'hF_FFFF);
    meter_run(17'h0_9c41, 20'hC_0001, 20'hF_FFFF);
  endtask
  task automatic bin_seq();
    logic [12:0] a;
    logic [12:0] b;
    bin_run(1'b1, 13'h0064, a);
    bin_run(1'b0, 13'h012c, b);
    check(20'(b - a), 20'h0_00c8);
  endtask
  initial
  begin
    err_count = 0;
    n_tests = 0;
    rst_n_i = 1'b0;
    meter_reset_n = 1'b1;
    pos = 1'b1;
    rr = 13'h0064;
    xfer_at = 17'h0_4e20;
    repeat (8) @(posedge clock_i);
    rst_n_i <= 1'b1;
    fork
      meter_seq();
      bin_seq();
    join
    stop_test();
  end
endmodule
`default_nettype wire
